// ---- include/smbus_proxy_params.svh ----
// constants for the management serial proxy target
`ifndef SMBUS_PROXY_PARAMS_SVH
`define SMBUS_PROXY_PARAMS_SVH

// ----------------------------------------
// slave addresses, command codes and target byte
// ----------------------------------------
`define ADDR_WRITE 7'h4C
`define ADDR_RESULT 7'h4B
`define CODE_PROXY 8'h62
`define CODE_RESET 8'h64
`define CODE_RESULT 8'h40
`define TARGET_SOCKET 8'h30

// ----------------------------------------
// byte framing
// ----------------------------------------
`define BITS_PER_BYTE 4'h8
`define LAST_BIT 4'h7
`define RW_READ 1'b1

`endif

// ---- include/smbus_proxy_pkg.sv ----
// types shared by the proxy target modules
package smbus_proxy_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_ACK = 3'h2,
      ST_FETCH = 3'h3,
      ST_TX = 3'h4,
      ST_MACK = 3'h5,
      ST_SKIP = 3'h6
   } link_state_e;

   typedef enum logic [1:0] {
      PH_ADDR = 2'h0,
      PH_CMD = 2'h1,
      PH_COUNT = 2'h2,
      PH_DATA = 2'h3
   } phase_e;

   typedef enum logic [1:0] {
      OP_WRITE = 2'h0,
      OP_RESET = 2'h1,
      OP_FETCH = 2'h2,
      OP_DONE = 2'h3
   } op_e;

endpackage : smbus_proxy_pkg

// ---- include/link_xfer_if.sv ----
// toggle handshake between link side and bridge side
`timescale 1ns/10ps
`default_nettype none

interface link_xfer_if;
   logic reqTog;
   smbus_proxy_pkg::op_e op;
   logic [7:0] wrData;
   logic wrLast;
   logic ackTog;
   logic [7:0] respData;
   logic busy;

   modport link (output reqTog, op, wrData, wrLast, input ackTog, respData, busy);
   modport bridge (input reqTog, op, wrData, wrLast, output ackTog, respData, busy);
endinterface : link_xfer_if

`default_nettype wire

// ---- logic/bridge_port.sv ----
// bridge-side end of the handshake, command and result ports
`timescale 1ns/10ps
`default_nettype none
`include "smbus_proxy_params.svh"

module bridge_port (
   input wire logic clk,
   input wire logic sys_rst,
   link_xfer_if.bridge xfer,
   input wire logic resultValid,
   input wire logic [7:0] resultCount,
   input wire logic [7:0] resultData,
   output logic [7:0] resultAddr,
   output logic resultTaken,
   output logic cmdValid,
   output logic [7:0] cmdData,
   output logic cmdLast,
   output logic cmdError,
   output logic bridgeReset
);
   logic reqMeta_ff, reqS_ff, reqOld_ff, newReq, errNow;
   logic busy_ff, first_ff, drop_ff, head_ff, ackTog_ff;
   logic nxt_busy, nxt_first, nxt_drop, nxt_head, nxt_ackTog;
   logic [7:0] addr_ff, resp_ff, data_ff, nxt_addr, nxt_resp, nxt_data;
   logic valid_ff, last_ff, err_ff, brst_ff, taken_ff;
   logic nxt_valid, nxt_last, nxt_err, nxt_brst, nxt_taken;

   // ----------------------------------------
   // request synchroniser
   // ----------------------------------------
   always_ff @(posedge clk) begin
      reqMeta_ff <= xfer.reqTog;
      reqS_ff <= reqMeta_ff;
      reqOld_ff <= reqS_ff;
   end
   assign newReq = reqS_ff ^ reqOld_ff;
   assign errNow = first_ff && (xfer.wrData != `TARGET_SOCKET);

   // ----------------------------------------
   // request decode
   // ----------------------------------------
   always_comb begin
      nxt_busy = busy_ff;
      nxt_first = first_ff;
      nxt_drop = drop_ff;
      nxt_head = head_ff;
      nxt_addr = addr_ff;
      nxt_resp = resp_ff;
      nxt_ackTog = ackTog_ff;
      nxt_data = data_ff;
      nxt_valid = 1'b0;
      nxt_last = 1'b0;
      nxt_err = 1'b0;
      nxt_brst = 1'b0;
      nxt_taken = 1'b0;
      if (newReq) begin
         nxt_ackTog = !ackTog_ff;
         unique case (xfer.op)
            smbus_proxy_pkg::OP_WRITE: begin
               nxt_err = errNow;
               if (!drop_ff && !errNow) begin
                  nxt_valid = 1'b1;
                  nxt_data = xfer.wrData;
                  nxt_last = xfer.wrLast;
               end
               nxt_first = xfer.wrLast;
               nxt_drop = !xfer.wrLast && (drop_ff || errNow);
               if (xfer.wrLast && !drop_ff && !errNow) begin
                  nxt_busy = 1'b1;
               end
            end
            smbus_proxy_pkg::OP_RESET: begin
               nxt_brst = 1'b1;
               nxt_busy = 1'b0;
               nxt_first = 1'b1;
               nxt_drop = 1'b0;
               nxt_head = 1'b1;
               nxt_addr = 8'h00;
            end
            smbus_proxy_pkg::OP_FETCH: begin
               if (head_ff) begin
                  nxt_resp = resultValid ? resultCount : 8'h00;
                  nxt_head = 1'b0;
               end else begin
                  nxt_resp = resultData;
                  nxt_addr = addr_ff + 8'h01;
               end
            end
            smbus_proxy_pkg::OP_DONE: begin
               nxt_taken = 1'b1;
               nxt_busy = 1'b0;
               nxt_head = 1'b1;
               nxt_addr = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         busy_ff <= 1'b0;
         first_ff <= 1'b1;
         drop_ff <= 1'b0;
         head_ff <= 1'b1;
         addr_ff <= 8'h00;
         resp_ff <= 8'h00;
         ackTog_ff <= 1'b0;
         data_ff <= 8'h00;
         valid_ff <= 1'b0;
         last_ff <= 1'b0;
         err_ff <= 1'b0;
         brst_ff <= 1'b0;
         taken_ff <= 1'b0;
      end else begin
         busy_ff <= nxt_busy;
         first_ff <= nxt_first;
         drop_ff <= nxt_drop;
         head_ff <= nxt_head;
         addr_ff <= nxt_addr;
         resp_ff <= nxt_resp;
         ackTog_ff <= nxt_ackTog;
         data_ff <= nxt_data;
         valid_ff <= nxt_valid;
         last_ff <= nxt_last;
         err_ff <= nxt_err;
         brst_ff <= nxt_brst;
         taken_ff <= nxt_taken;
      end
   end

   assign xfer.ackTog = ackTog_ff;
   assign xfer.respData = resp_ff;
   assign xfer.busy = busy_ff;
   assign resultAddr = addr_ff;
   assign resultTaken = taken_ff;
   assign cmdValid = valid_ff;
   assign cmdData = data_ff;
   assign cmdLast = last_ff;
   assign cmdError = err_ff;
   assign bridgeReset = brst_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   target_check_a: assert property (
      newReq && xfer.op == smbus_proxy_pkg::OP_WRITE && errNow |=> cmdError && !cmdValid)
      else $error("bad target address not flagged");
   bridge_reset_a: assert property (
      newReq && xfer.op == smbus_proxy_pkg::OP_RESET |=> bridgeReset && !busy_ff ##1 !bridgeReset)
      else $error("bridge reset not carried out");
   single_cmd_a: assert property (
      cmdValid && cmdLast |-> busy_ff until (bridgeReset || resultTaken))
      else $error("command ended without busy");
   count_first_a: assert property (
      newReq && xfer.op == smbus_proxy_pkg::OP_FETCH && head_ff
      |=> resp_ff == ($past(resultValid) ? $past(resultCount) : 8'h00))
      else $error("result count byte wrong");

endmodule : bridge_port

`default_nettype wire

// ---- logic/smbus_proxy_slave.sv ----
// management serial proxy target: link engine and bridge port
`timescale 1ns/10ps
`default_nettype none
`include "smbus_proxy_params.svh"

// Summary of operation
// - open-drain pins, driven only when function selected
// - no alert or suspend lines exist
// - slave only, never makes a start
// - one command at a time, no queue
// - only block write and block read
// - block write bytes acknowledged up to the byte count
// - block read returns count then data
// - write address, proxy and reset codes
// - result address and read code, counted block
// - target byte other than socket is error
module smbus_proxy_slave (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic linkClk,
   input wire logic mgmtPinSelect,
   input wire logic mgmtSerialClockPinIn,
   output logic mgmtSerialClockPinOut,
   output logic mgmtSerialClockPinOe_n,
   input wire logic mgmtSerialDataPinIn,
   output logic mgmtSerialDataPinOut,
   output logic mgmtSerialDataPinOe_n,
   output logic cmdValid,
   output logic [7:0] cmdData,
   output logic cmdLast,
   output logic cmdError,
   output logic bridgeReset,
   input wire logic resultValid,
   input wire logic [7:0] resultCount,
   input wire logic [7:0] resultData,
   output logic [7:0] resultAddr,
   output logic resultTaken
);
   link_xfer_if xfer ();

   logic rstMeta_ff, linkRst_ff;
   logic sclMeta_ff, sclS_ff, sclOld_ff, sdaMeta_ff, sdaS_ff, sdaOld_ff;
   logic selMeta_ff, selS_ff, busyMeta_ff, busyS_ff, ackMeta_ff, ackS_ff;
   logic sclRise, sclFall, startCond, stopCond, hsBusy, byteDone, sdaDrive;
   smbus_proxy_pkg::link_state_e state_ff, nxt_state;
   smbus_proxy_pkg::phase_e phase_ff, nxt_phase;
   smbus_proxy_pkg::op_e op_ff, nxt_op;
   logic [3:0] bitCnt_ff, nxt_bitCnt;
   logic [7:0] shift_ff, nxt_shift, code_ff, nxt_code, remain_ff, nxt_remain;
   logic [7:0] wrData_ff, nxt_wrData;
   logic ack_ff, nxt_ack, isRead_ff, nxt_isRead, isRes_ff, nxt_isRes;
   logic mAck_ff, nxt_mAck, reqTog_ff, nxt_reqTog, wrLast_ff, nxt_wrLast;

   // ----------------------------------------
   // link-domain synchronisers
   // ----------------------------------------
   always_ff @(posedge linkClk) begin
      rstMeta_ff <= sys_rst;
      linkRst_ff <= rstMeta_ff;
      sclMeta_ff <= mgmtSerialClockPinIn;
      sclS_ff <= sclMeta_ff;
      sclOld_ff <= sclS_ff;
      sdaMeta_ff <= mgmtSerialDataPinIn;
      sdaS_ff <= sdaMeta_ff;
      sdaOld_ff <= sdaS_ff;
      selMeta_ff <= mgmtPinSelect;
      selS_ff <= selMeta_ff;
      busyMeta_ff <= xfer.busy;
      busyS_ff <= busyMeta_ff;
      ackMeta_ff <= xfer.ackTog;
      ackS_ff <= ackMeta_ff;
   end

   assign sclRise = sclS_ff && !sclOld_ff;
   assign sclFall = !sclS_ff && sclOld_ff;
   assign startCond = sclS_ff && sclOld_ff && sdaOld_ff && !sdaS_ff;
   assign stopCond = sclS_ff && sclOld_ff && !sdaOld_ff && sdaS_ff;
   assign hsBusy = reqTog_ff != ackS_ff;
   assign byteDone = state_ff == smbus_proxy_pkg::ST_RX && bitCnt_ff == `BITS_PER_BYTE && sclFall;

   // ----------------------------------------
   // byte engine
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_phase = phase_ff;
      nxt_op = op_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_shift = shift_ff;
      nxt_code = code_ff;
      nxt_remain = remain_ff;
      nxt_wrData = wrData_ff;
      nxt_ack = ack_ff;
      nxt_isRead = isRead_ff;
      nxt_isRes = isRes_ff;
      nxt_mAck = mAck_ff;
      nxt_reqTog = reqTog_ff;
      nxt_wrLast = wrLast_ff;
      if (!selS_ff) begin
         nxt_state = smbus_proxy_pkg::ST_IDLE;
         nxt_code = 8'h00;
      end else if (startCond) begin
         nxt_state = smbus_proxy_pkg::ST_RX;
         nxt_phase = smbus_proxy_pkg::PH_ADDR;
         nxt_bitCnt = 4'h0;
      end else if (stopCond) begin
         nxt_state = smbus_proxy_pkg::ST_IDLE;
         nxt_code = 8'h00;
      end else begin
         unique case (state_ff)
            smbus_proxy_pkg::ST_IDLE, smbus_proxy_pkg::ST_SKIP: begin
            end
            smbus_proxy_pkg::ST_RX: begin
               if (sclRise && bitCnt_ff != `BITS_PER_BYTE) begin
                  nxt_shift = {shift_ff[6:0], sdaS_ff};
                  nxt_bitCnt = bitCnt_ff + 4'h1;
               end else if (byteDone) begin
                  nxt_state = smbus_proxy_pkg::ST_ACK;
                  nxt_ack = 1'b0;
                  unique case (phase_ff)
                     smbus_proxy_pkg::PH_ADDR: begin
                        nxt_isRead = shift_ff[0] == `RW_READ;
                        nxt_isRes = shift_ff[7:1] == `ADDR_RESULT;
                        nxt_phase = smbus_proxy_pkg::PH_CMD;
                        if (shift_ff[0] != `RW_READ) begin
                           nxt_ack = shift_ff[7:1] == `ADDR_WRITE
                              || shift_ff[7:1] == `ADDR_RESULT;
                        end else begin
                           nxt_ack = shift_ff[7:1] == `ADDR_RESULT
                              && code_ff == `CODE_RESULT;
                        end
                     end
                     smbus_proxy_pkg::PH_CMD: begin
                        nxt_phase = smbus_proxy_pkg::PH_COUNT;
                        if (isRes_ff) begin
                           nxt_ack = shift_ff == `CODE_RESULT;
                        end else begin
                           nxt_ack = (shift_ff == `CODE_PROXY && !busyS_ff)
                              || shift_ff == `CODE_RESET;
                        end
                        nxt_code = nxt_ack ? shift_ff : 8'h00;
                     end
                     smbus_proxy_pkg::PH_COUNT: begin
                        nxt_phase = smbus_proxy_pkg::PH_DATA;
                        nxt_remain = shift_ff;
                        if (code_ff == `CODE_PROXY) begin
                           nxt_ack = 1'b1;
                        end else if (code_ff == `CODE_RESET && shift_ff == 8'h00) begin
                           nxt_ack = 1'b1;
                           nxt_reqTog = !reqTog_ff;
                           nxt_op = smbus_proxy_pkg::OP_RESET;
                        end
                     end
                     smbus_proxy_pkg::PH_DATA: begin
                        if (code_ff == `CODE_PROXY && remain_ff != 8'h00) begin
                           nxt_ack = 1'b1;
                           nxt_remain = remain_ff - 8'h01;
                           nxt_reqTog = !reqTog_ff;
                           nxt_op = smbus_proxy_pkg::OP_WRITE;
                           nxt_wrData = shift_ff;
                           nxt_wrLast = remain_ff == 8'h01;
                        end
                     end
                  endcase
               end
            end
            smbus_proxy_pkg::ST_ACK: begin
               if (sclFall) begin
                  nxt_ack = 1'b0;
                  nxt_bitCnt = 4'h0;
                  if (!ack_ff) begin
                     nxt_state = smbus_proxy_pkg::ST_SKIP;
                  end else if (isRead_ff) begin
                     nxt_state = smbus_proxy_pkg::ST_FETCH;
                     nxt_reqTog = !reqTog_ff;
                     nxt_op = smbus_proxy_pkg::OP_FETCH;
                  end else begin
                     nxt_state = smbus_proxy_pkg::ST_RX;
                  end
               end
            end
            smbus_proxy_pkg::ST_FETCH: begin
               if (!hsBusy) begin
                  nxt_shift = xfer.respData;
                  nxt_state = smbus_proxy_pkg::ST_TX;
                  nxt_bitCnt = 4'h0;
               end
            end
            smbus_proxy_pkg::ST_TX: begin
               if (sclFall) begin
                  nxt_shift = {shift_ff[6:0], 1'b1};
                  nxt_bitCnt = bitCnt_ff + 4'h1;
                  if (bitCnt_ff == `LAST_BIT) begin
                     nxt_state = smbus_proxy_pkg::ST_MACK;
                  end
               end
            end
            smbus_proxy_pkg::ST_MACK: begin
               if (sclRise) begin
                  nxt_mAck = !sdaS_ff;
               end else if (sclFall) begin
                  nxt_reqTog = !reqTog_ff;
                  if (mAck_ff) begin
                     nxt_state = smbus_proxy_pkg::ST_FETCH;
                     nxt_op = smbus_proxy_pkg::OP_FETCH;
                  end else begin
                     nxt_state = smbus_proxy_pkg::ST_SKIP;
                     nxt_op = smbus_proxy_pkg::OP_DONE;
                  end
               end
            end
            default: begin
               nxt_state = smbus_proxy_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge linkClk) begin
      if (linkRst_ff) begin
         state_ff <= smbus_proxy_pkg::ST_IDLE;
         phase_ff <= smbus_proxy_pkg::PH_ADDR;
         op_ff <= smbus_proxy_pkg::OP_WRITE;
         bitCnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         code_ff <= 8'h00;
         remain_ff <= 8'h00;
         wrData_ff <= 8'h00;
         ack_ff <= 1'b0;
         isRead_ff <= 1'b0;
         isRes_ff <= 1'b0;
         mAck_ff <= 1'b0;
         reqTog_ff <= 1'b0;
         wrLast_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         phase_ff <= nxt_phase;
         op_ff <= nxt_op;
         bitCnt_ff <= nxt_bitCnt;
         shift_ff <= nxt_shift;
         code_ff <= nxt_code;
         remain_ff <= nxt_remain;
         wrData_ff <= nxt_wrData;
         ack_ff <= nxt_ack;
         isRead_ff <= nxt_isRead;
         isRes_ff <= nxt_isRes;
         mAck_ff <= nxt_mAck;
         reqTog_ff <= nxt_reqTog;
         wrLast_ff <= nxt_wrLast;
      end
   end

   // ----------------------------------------
   // pins and handshake
   // ----------------------------------------
   assign sdaDrive = selS_ff && ((state_ff == smbus_proxy_pkg::ST_ACK && ack_ff)
      || (state_ff == smbus_proxy_pkg::ST_TX && !shift_ff[7]));
   assign mgmtSerialDataPinOe_n = !sdaDrive;
   assign mgmtSerialDataPinOut = 1'b0;
   assign mgmtSerialClockPinOe_n = !(selS_ff && hsBusy
      && (state_ff == smbus_proxy_pkg::ST_ACK || state_ff == smbus_proxy_pkg::ST_FETCH));
   assign mgmtSerialClockPinOut = 1'b0;
   assign xfer.reqTog = reqTog_ff;
   assign xfer.op = op_ff;
   assign xfer.wrData = wrData_ff;
   assign xfer.wrLast = wrLast_ff;

   bridge_port bridge (
      .clk(clk),
      .sys_rst(sys_rst),
      .xfer(xfer),
      .resultValid(resultValid),
      .resultCount(resultCount),
      .resultData(resultData),
      .resultAddr(resultAddr),
      .resultTaken(resultTaken),
      .cmdValid(cmdValid),
      .cmdData(cmdData),
      .cmdLast(cmdLast),
      .cmdError(cmdError),
      .bridgeReset(bridgeReset)
   );

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking lcb @(posedge linkClk); endclocking
   default disable iff (linkRst_ff);

   sequence addrEnd;
      byteDone && phase_ff == smbus_proxy_pkg::PH_ADDR;
   endsequence
   sequence dataEnd;
      byteDone && phase_ff == smbus_proxy_pkg::PH_DATA;
   endsequence

   no_start_a: assert property ($fell(mgmtSerialDataPinOe_n) |-> !sclS_ff)
      else $error("data driven while clock high");
   pin_release_a: assert property (
      !selS_ff |-> mgmtSerialDataPinOe_n && mgmtSerialClockPinOe_n)
      else $error("pins driven while unselected");
   addr_nack_a: assert property (
      addrEnd ##0 (shift_ff[7:1] != `ADDR_WRITE && shift_ff[7:1] != `ADDR_RESULT)
      |=> !ack_ff ##0 mgmtSerialDataPinOe_n)
      else $error("foreign address acknowledged");
   rw_bit_a: assert property (addrEnd |=> isRead_ff == $past(shift_ff[0]))
      else $error("direction bit misread");
   data_ack_a: assert property (
      dataEnd ##0 (code_ff == `CODE_PROXY && remain_ff != 8'h00)
      |=> ack_ff && hsBusy && xfer.wrData == $past(shift_ff))
      else $error("payload byte not taken");
   busy_nack_a: assert property (
      byteDone && phase_ff == smbus_proxy_pkg::PH_CMD && !isRes_ff && busyS_ff
      && shift_ff == `CODE_PROXY |=> !ack_ff)
      else $error("second command accepted");
   fetch_bound_a: assert property (
      state_ff == smbus_proxy_pkg::ST_FETCH |-> ##[0:16] state_ff != smbus_proxy_pkg::ST_FETCH)
      else $error("result byte fetch stalled");

endmodule : smbus_proxy_slave

`default_nettype wire

// ---- tb/smbus_bmc_model.sv ----
// bus master model for the management serial link
`timescale 1ns/10ps
`default_nettype none
module smbus_bmc_model (
   input wire logic linkClk,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sclLow,
   output logic sdaLow
);
   int stuck = 0;
   initial begin
      sclLow = 1'b0;
      sdaLow = 1'b0;
   end
   task automatic q();
      repeat (3) @(negedge linkClk);
   endtask : q
   // release clock, wait out stretching
   task automatic rise();
      int n;
      sclLow = 1'b0;
      n = 0;
      while (sclIn !== 1'b1 && n < 64) begin
         @(negedge linkClk);
         n++;
      end
      if (n == 64) stuck++;
      q();
   endtask : rise
   // start or repeated start, made only by the master
   task automatic start();
      sdaLow = 1'b0;
      q();
      rise();
      sdaLow = 1'b1;
      q();
      sclLow = 1'b1;
      q();
   endtask : start
   task automatic stop();
      sdaLow = 1'b1;
      q();
      rise();
      sdaLow = 1'b0;
      q();
   endtask : stop
   // eight bits msb first, then the ack bit
   task automatic xfer(input logic [7:0] d, input logic mAck, output logic [7:0] r,
                       output logic ack);
      for (int i = 8; i >= 0; i--) begin
         sdaLow = (i > 0) ? !d[i-1] : mAck;
         q();
         rise();
         if (i > 0) r[i-1] = sdaIn;
         else ack = !sdaIn;
         sclLow = 1'b1;
         q();
      end
   endtask : xfer
endmodule : smbus_bmc_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the proxy serial target
`timescale 1ns/10ps
`default_nettype none
`include "smbus_proxy_params.svh"
module testbench;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic sysRst = 1'b1;
   logic pinSel = 1'b1;
   logic resultValid = 1'b0;
   logic [7:0] resultCount = 8'h00;
   logic [7:0] resultData = 8'h00;
   logic sclOe_n, sdaOe_n, cmdValid, cmdLast, cmdError, bridgeReset, resultTaken;
   logic sclLow, sdaLow, ack, sclOut, sdaOut;
   logic [7:0] cmdData, resultAddr, r;
   logic [7:0] rx[$];
   int numErrors = 0, testsRun = 0, nLast = 0, nErr = 0, nRst = 0, nTaken = 0;
   wire sclWire = !(sclLow || (!sclOe_n && !sclOut));
   wire sdaWire = !(sdaLow || (!sdaOe_n && !sdaOut));
   initial forever #2 clk = !clk;
   initial begin
      #5;
      forever #32 linkClk = !linkClk;
   end
   smbus_proxy_slave DUT (
      .clk(clk),
      .sys_rst(sysRst),
      .linkClk(linkClk),
      .mgmtPinSelect(pinSel),
      .mgmtSerialClockPinIn(sclWire),
      .mgmtSerialClockPinOut(sclOut),
      .mgmtSerialClockPinOe_n(sclOe_n),
      .mgmtSerialDataPinIn(sdaWire),
      .mgmtSerialDataPinOut(sdaOut),
      .mgmtSerialDataPinOe_n(sdaOe_n),
      .cmdValid(cmdValid),
      .cmdData(cmdData),
      .cmdLast(cmdLast),
      .cmdError(cmdError),
      .bridgeReset(bridgeReset),
      .resultValid(resultValid),
      .resultCount(resultCount),
      .resultData(resultData),
      .resultAddr(resultAddr),
      .resultTaken(resultTaken)
   );
   smbus_bmc_model bmc (
      .linkClk(linkClk),
      .sclIn(sclWire),
      .sdaIn(sdaWire),
      .sclLow(sclLow),
      .sdaLow(sdaLow)
   );
   always @(negedge clk) begin
      if (cmdValid === 1'b1) rx.push_back(cmdData);
      if (cmdLast === 1'b1) nLast++;
      if (cmdError === 1'b1) nErr++;
      if (bridgeReset === 1'b1) nRst++;
      if (resultTaken === 1'b1) nTaken++;
   end
   always @(negedge clk) resultData <= 8'hC0 | resultAddr;
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      testsRun++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         numErrors++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] d, input logic expAck);
      bmc.xfer(d, 1'b0, r, ack);
      chk("ack", {7'h00, expAck}, {7'h00, ack});
   endtask : wr
   task automatic rd(input string name, input logic [7:0] exp, input logic mAck);
      bmc.xfer(8'hFF, mAck, r, ack);
      chk(name, exp, r);
   endtask : rd
   task automatic t_proxy();
      bmc.start();
      wr({`ADDR_WRITE, 1'b0}, 1'b1);
      wr(`CODE_PROXY, 1'b1);
      wr(8'h03, 1'b1);
      wr(`TARGET_SOCKET, 1'b1);
      wr(8'hA5, 1'b1);
      wr(8'h5A, 1'b1);
      bmc.stop();
      chk("bytes", 8'h03, 8'(rx.size()));
      chk("byte0", `TARGET_SOCKET, rx[0]);
      chk("byte2", 8'h5A, rx[2]);
      chk("last", 8'h01, 8'(nLast));
      bmc.start();
      wr({`ADDR_WRITE, 1'b0}, 1'b1);
      wr(`CODE_PROXY, 1'b0);
      bmc.stop();
   endtask : t_proxy
   task automatic t_read();
      @(negedge clk);
      resultValid = 1'b1;
      resultCount = 8'h02;
      bmc.start();
      wr({`ADDR_RESULT, 1'b0}, 1'b1);
      wr(`CODE_RESULT, 1'b1);
      bmc.start();
      wr({`ADDR_RESULT, `RW_READ}, 1'b1);
      rd("rcount", 8'h02, 1'b1);
      rd("rdata0", 8'hC0, 1'b1);
      rd("rdata1", 8'hC1, 1'b0);
      bmc.stop();
      chk("taken", 8'h01, 8'(nTaken));
   endtask : t_read
   task automatic t_error();
      bmc.start();
      wr({`ADDR_WRITE, 1'b0}, 1'b1);
      wr(`CODE_PROXY, 1'b1);
      wr(8'h01, 1'b1);
      wr(8'h31, 1'b1);
      bmc.stop();
      chk("error", 8'h01, 8'(nErr));
   endtask : t_error
   task automatic t_reset();
      bmc.start();
      wr({`ADDR_WRITE, 1'b0}, 1'b1);
      wr(`CODE_PROXY, 1'b1);
      wr(8'h01, 1'b1);
      wr(`TARGET_SOCKET, 1'b1);
      bmc.stop();
      chk("held", 8'h02, 8'(nLast));
      bmc.start();
      wr({`ADDR_WRITE, 1'b0}, 1'b1);
      wr(`CODE_RESET, 1'b1);
      wr(8'h01, 1'b0);
      bmc.stop();
      bmc.start();
      wr({`ADDR_WRITE, 1'b0}, 1'b1);
      wr(`CODE_RESET, 1'b1);
      wr(8'h00, 1'b1);
      bmc.stop();
      chk("reset", 8'h01, 8'(nRst));
      bmc.start();
      wr({`ADDR_WRITE, 1'b0}, 1'b1);
      wr(`CODE_PROXY, 1'b1);
      wr(8'h00, 1'b1);
      bmc.stop();
   endtask : t_reset
   task automatic t_refuse();
      logic [7:0] bad[3] = '{8'h99, 8'h97, 8'hA0};
      foreach (bad[i]) begin
         bmc.start();
         wr(bad[i], 1'b0);
         bmc.stop();
      end
      @(negedge clk);
      pinSel = 1'b0;
      repeat (8) @(posedge linkClk);
      bmc.start();
      wr({`ADDR_WRITE, 1'b0}, 1'b0);
      bmc.stop();
   endtask : t_refuse
   task automatic report_and_stop();
      $display("errors %0d checks %0d", numErrors, testsRun);
      if (numErrors == 0 && testsRun > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   initial begin
      #400000;
      numErrors++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge linkClk);
      @(negedge clk);
      sysRst = 1'b0;
      repeat (8) @(posedge linkClk);
      t_proxy();
      t_read();
      t_error();
      t_reset();
      t_refuse();
      chk("stuck", 8'h00, 8'(bmc.stuck));
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
